// ===== bench/mem_responder.sv
// downstream memory stand-in that accepts accesses after a chosen stall
`timescale 1ns/1ps
`default_nettype none

module mem_responder (
    input  wire logic       clock_i,     // bus clock
    input  wire logic       sys_rst_i,   // sync reset, active high
    input  wire logic       mem_valid_i, // access offered by the checker
    input  wire logic [3:0] stall_i,     // wait cycles before accepting
    output logic            mem_ready_o  // access taken when high with valid
);
    logic [3:0] wait_q;

    // each access starts counting from zero, so a stall applies to both halves of a mismatch
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !mem_valid_i || mem_ready_o) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end

    // accesses stop at the permission check point; nothing further down is modelled
    assign mem_ready_o = mem_valid_i && (wait_q >= stall_i);
endmodule : mem_responder

`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the identifier permission checker
`timescale 1ns/1ps
`default_nettype none

`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", name, exp, got); end end

module tb_top
    import nsaid_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        req_valid_i = 1'b0, req_write_i = 1'b0, req_snooped_i = 1'b0;
    logic [31:0] req_addr_i = 32'h0000_1000;
    logic [3:0]  req_nsaid_i = 4'h0, snp_nsaid_i = 4'h0, perm_id_i = 4'h0, mem_stall = 4'h0;
    logic [2:0]  req_prot_i = 3'h2;
    logic [1:0]  perm_val_i = 2'h0, snp_in_op_i = 2'h0, snp_out_op_o;
    logic        perm_we_i = 1'b0, protect_en_i = 1'b0, snp_in_valid_i = 1'b0;
    logic        req_ready_o, mem_valid_o, mem_ready_i, mem_write_o, resp_valid_o;
    logic        resp_err_o, resp_fwd_o, perm_changed_o, snp_out_valid_o;
    logic [31:0] mem_addr_o;
    logic [3:0]  mem_nsaid_o;
    int          failures = 0, cmp_count = 0;
    logic        hs_wr[$];
    logic [3:0]  hs_id[$];
    logic [31:0] hs_addr[$];

    always #2.5 clock_i = ~clock_i;

    nsaid_checker u_nsaid_checker (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_nsaid_i(req_nsaid_i), .req_prot_i(req_prot_i),
        .req_snooped_i(req_snooped_i), .snp_nsaid_i(snp_nsaid_i), .mem_valid_o(mem_valid_o),
        .mem_ready_i(mem_ready_i), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
        .mem_nsaid_o(mem_nsaid_o), .resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o),
        .resp_fwd_o(resp_fwd_o), .perm_we_i(perm_we_i), .perm_id_i(perm_id_i),
        .perm_val_i(perm_val_i), .perm_changed_o(perm_changed_o), .protect_en_i(protect_en_i),
        .snp_in_valid_i(snp_in_valid_i), .snp_in_op_i(snp_in_op_i),
        .snp_out_valid_o(snp_out_valid_o), .snp_out_op_o(snp_out_op_o));

    mem_responder u_mem_responder (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .mem_valid_i(mem_valid_o), .stall_i(mem_stall), .mem_ready_o(mem_ready_i));

    // log every downstream handshake as it happens
    always @(posedge clock_i) begin
        if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1) begin
            hs_wr.push_back(mem_write_o);
            hs_id.push_back(mem_nsaid_o);
            hs_addr.push_back(mem_addr_o);
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // one request end to end; the master drives the identifier with it
    task automatic do_req(input logic wr, input logic [3:0] id, input logic [2:0] prot,
                          input logic snp, input logic [3:0] sid, input logic e_err,
                          input logic e_fwd, input int e_mem, input logic [3:0] e_id0);
        int k;
        k = 0;
        hs_wr.delete();
        hs_id.delete();
        hs_addr.delete();
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_nsaid_i <= id;
        req_prot_i <= prot;
        req_snooped_i <= snp;
        snp_nsaid_i <= sid;
        #1;
        `CHK("req_ready_o", 1'b1, req_ready_o)
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1;
        while (resp_valid_o !== 1'b1 && k < 50) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        if (resp_valid_o !== 1'b1) begin
            failures++;
            final_report();
        end
        `CHK("resp_err_o", e_err, resp_err_o)
        `CHK("resp_fwd_o", e_fwd, resp_fwd_o)
        `CHK("mem accesses", e_mem, hs_wr.size())
        if (e_mem > 0 && hs_wr.size() > 0) begin
            `CHK("first mem write", (e_mem == 2) ? 1'b1 : wr, hs_wr[0])
            `CHK("first mem id", e_id0, hs_id[0])
            `CHK("first mem addr", req_addr_i, hs_addr[0])
        end
        if (e_mem == 2 && hs_wr.size() == 2) begin
            `CHK("reread write", 1'b0, hs_wr[1])
            `CHK("reread id", id, hs_id[1])
            `CHK("reread addr", req_addr_i, hs_addr[1])
        end
    endtask : do_req

    // permission update must be flagged for cache maintenance
    task automatic set_perm(input logic [3:0] id, input perm_t p);
        @(posedge clock_i);
        perm_we_i <= 1'b1;
        perm_id_i <= id;
        perm_val_i <= p;
        @(posedge clock_i);
        perm_we_i <= 1'b0;
        #1;
        `CHK("perm_changed_o", 1'b1, perm_changed_o)
    endtask : set_perm

    task automatic t_reset();
        `CHK("reset ready", 1'b1, req_ready_o)
        `CHK("reset mem_valid", 1'b0, mem_valid_o)
        `CHK("reset resp_valid", 1'b0, resp_valid_o)
        `CHK("reset snp_out_valid", 1'b0, snp_out_valid_o)
        `CHK("reset perm_changed", 1'b0, perm_changed_o)
    endtask : t_reset

    // id 0 is open by default, others start closed
    task automatic t_default();
        do_req(1'b0, 4'h0, 3'h2, 1'b0, 4'h0, 1'b0, 1'b0, 1, 4'h0);
        do_req(1'b1, 4'h0, 3'h2, 1'b0, 4'h0, 1'b0, 1'b0, 1, 4'h0);
        do_req(1'b0, 4'h5, 3'h2, 1'b0, 4'h0, 1'b1, 1'b0, 0, 4'h0);
    endtask : t_default

    // every level on two ids, same address, with a slow memory
    task automatic t_levels();
        logic [3:0] ids[2] = '{4'h3, 4'hF};
        mem_stall = 4'h2;
        foreach (ids[i]) begin
            for (int p = 0; p < 4; p++) begin
                set_perm(ids[i], perm_t'(p[1:0]));
                for (int w = 0; w < 2; w++) begin
                    do_req(w[0], ids[i], 3'h2, 1'b0, 4'h0, !p[w], 1'b0, p[w], ids[i]);
                end
            end
        end
        mem_stall = 4'h0;
    endtask : t_levels

    // a secure request is checked as id 0 even with a closed id on the bus
    task automatic t_secure();
        set_perm(4'h3, PERM_NONE);
        do_req(1'b1, 4'h3, 3'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1, 4'h0);
        do_req(1'b1, 4'h3, 3'h2, 1'b0, 4'h0, 1'b1, 1'b0, 0, 4'h0);
    endtask : t_secure

    // snooped reads: match forwards, mismatch moves the line through memory
    task automatic t_snoop();
        set_perm(4'h4, PERM_RW);
        do_req(1'b0, 4'h0, 3'h2, 1'b1, 4'h0, 1'b0, 1'b1, 0, 4'h0);
        mem_stall = 4'h3;
        do_req(1'b0, 4'h0, 3'h2, 1'b1, 4'h4, 1'b0, 1'b0, 2, 4'h4);
        mem_stall = 4'h0;
        do_req(1'b0, 4'h0, 3'h2, 1'b1, 4'h6, 1'b1, 1'b0, 0, 4'h0);
    endtask : t_snoop

    // multi-id master hit with a new id: clean with the old id, then refetch with the new one
    task automatic t_refetch();
        do_req(1'b1, 4'h4, 3'h2, 1'b0, 4'h0, 1'b0, 1'b0, 1, 4'h4);
        do_req(1'b0, 4'h0, 3'h2, 1'b0, 4'h0, 1'b0, 1'b0, 1, 4'h0);
    endtask : t_refetch

    // every snoop kind with protection off and on
    task automatic t_snoop_ops();
        for (int pe = 0; pe < 2; pe++) begin
            for (int op = 0; op < 4; op++) begin
                @(posedge clock_i);
                snp_in_valid_i <= 1'b1;
                snp_in_op_i <= op[1:0];
                protect_en_i <= pe[0];
                @(posedge clock_i);
                snp_in_valid_i <= 1'b0;
                #1;
                `CHK("snp_out_valid_o", 1'b1, snp_out_valid_o)
                `CHK("snp_out_op_o", (pe == 1 && op == 3) ? 2'h2 : op[1:0], snp_out_op_o)
            end
        end
    endtask : t_snoop_ops

    initial begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        t_reset();
        t_default();
        t_levels();
        t_secure();
        t_snoop();
        t_refetch();
        t_snoop_ops();
        final_report();
    end
endmodule : tb_top

`default_nettype wire

// ===== hw/nsaid_checker.sv
// identifier permission checker with snoop mismatch resolution
`timescale 1ns/1ps
`default_nettype none
`include "nsaid_defines.svh"

// Summary of operation
// - with identifier support on, both read and write identifiers are used
// - support off or undeclared means identifiers are ignored and read as zero
// - snoop-response identifier is optional, only on coherent data-supplying masters
// - identifier is four bits, sixteen values, each with its own permissions
// - each identifier has none, read, write or read/write permission
// - identifiers may overlap regions with any permission mix
// - identifier zero is the supported default
// - matching snoop identifier lets snooped data go straight to requester
// - mismatch: write line with snoop identifier, then reread with request identifier
// - with protection on, invalidate-only snoops become clean-and-invalidate
// - snoop-caused memory writes use the snoop response identifier
// - permission changes require cache maintenance
// - cached writes without permission never reach memory or other identifiers
module nsaid_checker
    import nsaid_pkg::*;
#(
    parameter bit NSAID_PRESENT     = 1'b1,  // identifier signals carried
    parameter bit SNP_NSAID_PRESENT = 1'b1,  // snoop-response identifier carried
    parameter int ADDR_W            = 32,
    parameter int NUM_IDS           = `NSAID_NUM,
    parameter int ID_W              = `NSAID_W
) (
    input  wire logic               clock_i,         // bus clock, 200 MHz
    input  wire logic               sys_rst_i,       // sync reset, active high
    input  wire logic               req_valid_i,     // request offered
    output logic                    req_ready_o,     // request taken when both high
    input  wire logic               req_write_i,     // 1 write, 0 read
    input  wire logic [ADDR_W-1:0]  req_addr_i,      // request address
    input  wire logic [ID_W-1:0]    req_nsaid_i,     // request identifier
    input  wire logic [`PROT_W-1:0] req_prot_i,      // protection bits
    input  wire logic               req_snooped_i,   // read was served by a snoop
    input  wire logic [ID_W-1:0]    snp_nsaid_i,     // identifier from snoop response
    output logic                    mem_valid_o,     // downstream access offered
    input  wire logic               mem_ready_i,     // downstream access taken
    output logic                    mem_write_o,     // downstream access is a write
    output logic      [ADDR_W-1:0]  mem_addr_o,      // downstream address
    output logic      [ID_W-1:0]    mem_nsaid_o,     // downstream identifier
    output logic                    resp_valid_o,    // one-cycle completion
    output logic                    resp_err_o,      // completion refused
    output logic                    resp_fwd_o,      // snooped data goes to requester
    input  wire logic               perm_we_i,       // permission update strobe
    input  wire logic [ID_W-1:0]    perm_id_i,       // identifier to update
    input  wire logic [`PERM_W-1:0] perm_val_i,      // new permission
    output logic                    perm_changed_o,  // maintenance needed, one pulse
    input  wire logic               protect_en_i,    // memory protection active
    input  wire logic               snp_in_valid_i,  // snoop to issue
    input  wire logic [1:0]         snp_in_op_i,     // snoop kind requested
    output logic                    snp_out_valid_o, // snoop issued
    output logic      [1:0]         snp_out_op_o     // snoop kind issued
);

    logic [NUM_IDS*`PERM_W-1:0] perm_vec;
    state_t                     state_q;
    logic [ID_W-1:0]            req_id_eff;
    logic [ID_W-1:0]            snp_id_eff;
    logic                       req_ok;
    logic                       wb_ok;
    logic                       take;
    logic [ADDR_W-1:0]          addr_q;
    logic [ID_W-1:0]            req_id_q;

    // look up whether an identifier may do a read or a write
    function automatic logic perm_allows(input logic [NUM_IDS*`PERM_W-1:0] vec,
                                         input logic [ID_W-1:0]            id,
                                         input logic                       wr);
        logic [`PERM_W-1:0] p;
        p = vec[id*`PERM_W +: `PERM_W];
        return wr ? p[`PERM_WR_BIT] : p[`PERM_RD_BIT];
    endfunction : perm_allows

    nsaid_perm_table #(
        .NUM_IDS (NUM_IDS),
        .ID_W    (ID_W)
    ) u_table (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .we_i       (perm_we_i),
        .id_i       (perm_id_i),
        .perm_i     (perm_val_i),
        .perm_vec_o (perm_vec)
    );

    // absent or secure identifiers collapse to the default value
    assign req_id_eff = (NSAID_PRESENT && req_prot_i[`PROT_NS_BIT]) ? req_nsaid_i
                                                                    : `NSAID_DEFAULT;
    assign snp_id_eff = (NSAID_PRESENT && SNP_NSAID_PRESENT) ? snp_nsaid_i
                                                             : `NSAID_DEFAULT;
    // each identifier checked against its own entry, any mix allowed
    assign req_ok = perm_allows(perm_vec, req_id_eff, req_write_i);
    assign wb_ok  = perm_allows(perm_vec, snp_id_eff, 1'b1);
    assign take   = req_valid_i && req_ready_o;

    // handshakes straight from the state
    assign req_ready_o  = (state_q == ST_IDLE);
    assign mem_valid_o  = (state_q == ST_MEM) || (state_q == ST_WB) || (state_q == ST_RR);
    assign resp_valid_o = (state_q == ST_RESP);

    // request sequencer; one request at a time keeps ordering trivial
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        if (!req_ok) begin
                            state_q <= ST_RESP;
                        end else if (!req_write_i && req_snooped_i) begin
                            if (snp_id_eff == req_id_eff) begin
                                state_q <= ST_RESP;
                            end else if (!wb_ok) begin
                                state_q <= ST_RESP;
                            end else begin
                                state_q <= ST_WB;
                            end
                        end else begin
                            state_q <= ST_MEM;
                        end
                    end
                end
                ST_MEM:  if (mem_ready_i) state_q <= ST_RESP;
                ST_WB:   if (mem_ready_i) state_q <= ST_RR;
                ST_RR:   if (mem_ready_i) state_q <= ST_RESP;
                ST_RESP: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // captured request fields for the reread after a writeback
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            addr_q   <= '0;
            req_id_q <= `NSAID_DEFAULT;
        end else if (take) begin
            addr_q   <= req_addr_i;
            req_id_q <= req_id_eff;
        end
    end

    // downstream access fields; writeback carries the snoop identifier
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mem_write_o <= 1'b0;
            mem_addr_o  <= '0;
            mem_nsaid_o <= `NSAID_DEFAULT;
        end else if (take) begin
            mem_addr_o <= req_addr_i;
            if (!req_write_i && req_snooped_i) begin
                mem_write_o <= 1'b1;
                mem_nsaid_o <= snp_id_eff;
            end else begin
                mem_write_o <= req_write_i;
                mem_nsaid_o <= req_id_eff;
            end
        end else if (state_q == ST_WB && mem_ready_i) begin
            mem_write_o <= 1'b0;
            mem_addr_o  <= addr_q;
            mem_nsaid_o <= req_id_q;
        end
    end

    // completion flags decided at acceptance, held until the response
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            resp_err_o <= 1'b0;
            resp_fwd_o <= 1'b0;
        end else if (take) begin
            resp_err_o <= !req_ok ||
                          (!req_write_i && req_snooped_i &&
                           snp_id_eff != req_id_eff && !wb_ok);
            resp_fwd_o <= req_ok && !req_write_i && req_snooped_i &&
                          (snp_id_eff == req_id_eff);
        end
    end

    // any permission update tells the cache side to run maintenance
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            perm_changed_o <= 1'b0;
        end else begin
            perm_changed_o <= perm_we_i;
        end
    end

    // invalidate-only snoops would drop dirty data past the checker
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            snp_out_valid_o <= 1'b0;
            snp_out_op_o    <= SNP_READ_SHARED;
        end else begin
            snp_out_valid_o <= snp_in_valid_i;
            if (protect_en_i && snp_in_op_i == SNP_MAKE_INVALID) begin
                snp_out_op_o <= SNP_CLEAN_INVALID;
            end else begin
                snp_out_op_o <= snp_in_op_i;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_mismatch_take;
        take && req_ok && !req_write_i && req_snooped_i && snp_id_eff != req_id_eff && wb_ok;
    endsequence

    // writeback taken downstream; a stall may stretch it, so key off the accepting edge
    sequence s_wb_accept;
        state_q == ST_WB && mem_valid_o && mem_write_o && mem_ready_i;
    endsequence

    chk_denied_no_access: assert property (
        take && !req_ok |=> resp_valid_o && resp_err_o && !mem_valid_o)
        else $error("refused request reached memory");

    chk_fwd_on_match: assert property (
        take && req_ok && !req_write_i && req_snooped_i && snp_id_eff == req_id_eff
        |=> resp_valid_o && resp_fwd_o && !resp_err_o)
        else $error("matching snoop not forwarded");

    chk_wb_snoop_id: assert property (
        s_mismatch_take |=> mem_valid_o && mem_write_o && mem_nsaid_o == $past(snp_id_eff))
        else $error("writeback without snoop identifier");

    chk_reread_order: assert property (
        s_wb_accept
        |=> mem_valid_o && !mem_write_o && mem_nsaid_o == req_id_q && mem_addr_o == addr_q)
        else $error("reread missing or wrong identifier");

    chk_secure_zero: assert property (
        take && !req_prot_i[`PROT_NS_BIT] && req_ok && !req_snooped_i
        |=> mem_nsaid_o == `NSAID_DEFAULT)
        else $error("secure request carried identifier");

    chk_no_make_inv: assert property (
        protect_en_i && snp_in_valid_i && snp_in_op_i == SNP_MAKE_INVALID
        |=> snp_out_valid_o && snp_out_op_o == SNP_CLEAN_INVALID)
        else $error("invalidate-only snoop issued");

    chk_perm_notice: assert property (
        perm_we_i |=> perm_changed_o)
        else $error("permission change not flagged");

    chk_write_perm: assert property (
        mem_valid_o && mem_write_o |-> perm_allows(perm_vec, mem_nsaid_o, 1'b1)
                                       || $past(perm_we_i))
        else $error("write issued without permission");

    chk_resp_one_cycle: assert property (
        resp_valid_o |=> !resp_valid_o && req_ready_o)
        else $error("response held too long");

endmodule : nsaid_checker

`default_nettype wire

// ===== hw/nsaid_perm_table.sv
// per-identifier permission storage with one write port
`timescale 1ns/1ps
`default_nettype none
`include "nsaid_defines.svh"

module nsaid_perm_table
    import nsaid_pkg::*;
#(
    parameter int NUM_IDS = `NSAID_NUM,
    parameter int ID_W    = `NSAID_W
) (
    input  wire logic                        clock_i,    // bus clock
    input  wire logic                        sys_rst_i,  // sync reset, active high
    input  wire logic                        we_i,       // write one entry
    input  wire logic [ID_W-1:0]             id_i,       // entry to write
    input  wire logic [`PERM_W-1:0]          perm_i,     // new permission level
    output logic      [NUM_IDS*`PERM_W-1:0]  perm_vec_o  // all entries, flattened
);

    logic [`PERM_W-1:0] perm_q [NUM_IDS];

    // identifier zero defaults to full access so untagged masters keep working
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NUM_IDS; i++) begin
                perm_q[i] <= (i == 0) ? `PERM_RESET_DEFAULT : `PERM_RESET_OTHER;
            end
        end else if (we_i) begin
            perm_q[id_i] <= perm_i;
        end
    end

    // flatten the table for the lookups
    always_comb begin
        for (int i = 0; i < NUM_IDS; i++) begin
            perm_vec_o[i*`PERM_W +: `PERM_W] = perm_q[i];
        end
    end

endmodule : nsaid_perm_table

`default_nettype wire

// ===== pkg/nsaid_defines.svh
// constants for the non-secure access identifier checker
`ifndef NSAID_DEFINES_SVH
`define NSAID_DEFINES_SVH

`define NSAID_W            4
`define NSAID_NUM          16
`define NSAID_DEFAULT      4'h0
`define PERM_W             2
`define PERM_RD_BIT        0
`define PERM_WR_BIT        1
`define PROT_W             3
`define PROT_NS_BIT        1
`define PERM_RESET_DEFAULT 2'h3
`define PERM_RESET_OTHER   2'h0

`endif

// ===== pkg/nsaid_pkg.sv
// types shared by the identifier checker and its permission table
`include "nsaid_defines.svh"
`default_nettype none

package nsaid_pkg;

    // permission level per identifier, bit 0 read, bit 1 write
    typedef enum logic [1:0] {
        PERM_NONE = 2'h0,
        PERM_RD   = 2'h1,
        PERM_WR   = 2'h2,
        PERM_RW   = 2'h3
    } perm_t;

    // snoop kinds the interconnect may issue
    typedef enum logic [1:0] {
        SNP_READ_SHARED   = 2'h0,
        SNP_READ_UNIQUE   = 2'h1,
        SNP_CLEAN_INVALID = 2'h2,
        SNP_MAKE_INVALID  = 2'h3
    } snoop_op_t;

    // request sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_MEM  = 3'h1,
        ST_WB   = 3'h2,
        ST_RR   = 3'h3,
        ST_RESP = 3'h4
    } state_t;

endpackage : nsaid_pkg

`default_nettype wire
